// *** shared/cdd_pkg.sv ***
// Shared constants and types for the coil direct drive and emergency stop block.
package cdd_pkg;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 32;
    // Device register addresses on the link.
    localparam logic [6:0] ADDR_GLOBAL_CONFIGURATION = 7'h00;
    localparam logic [6:0] ADDR_RUN_HOLD_CURRENT = 7'h10;
    localparam logic [6:0] ADDR_STANDSTILL_TIMEOUT = 7'h11;
    localparam logic [6:0] ADDR_VOLTAGE_CHOPPER_THRESHOLD = 7'h13;
    localparam logic [6:0] ADDR_COIL_DIRECT_VALUE = 7'h2d;
    localparam logic [6:0] ADDR_CHOPPER_CONFIGURATION = 7'h6c;
    localparam logic [6:0] ADDR_VOLTAGE_CHOPPER_CONFIGURATION = 7'h70;
    // Global configuration field positions.
    localparam int unsigned GC_PWM_MODE_BIT = 2;
    localparam int unsigned GC_DIRECT_MODE_BIT = 16;
    localparam int unsigned GC_STOP_ENABLE_BIT = 15;
    // Coil direct value field positions.
    localparam int unsigned COIL_A_LSB = 0;
    localparam int unsigned COIL_B_LSB = 16;
    localparam int unsigned COIL_W = 9;
    // Run/hold current field positions.
    localparam int unsigned HOLD_LSB = 0;
    localparam int unsigned RUN_LSB = 8;
    localparam int unsigned HOLD_DELAY_LSB = 16;
    // Chopper configuration: off time in bits 3..0.
    localparam int unsigned OFF_TIME_LSB = 0;
    // Voltage chopper configuration fields.
    localparam int unsigned AMPL_LSB = 0;
    localparam int unsigned AUTOSCALE_BIT = 18;
    localparam int unsigned OPTION_A_LSB = 20;
    localparam logic [1:0] OPTION_A_OPTION_A = 2'b01;
    localparam logic [4:0] CURRENT_SCALE_MAX = 5'h1f;
    // Enable input takes this many clocks to switch the stage off.
    localparam int unsigned SHUTDOWN_CYCLES = 3;
    // Hold ramp step and standstill timeout clock bases.
    localparam int unsigned HOLD_RAMP_TICK = 16;
    localparam int unsigned TIMEOUT_TICK = 256;
    // Host controller registers on Wishbone (byte addresses).
    localparam logic [3:0] HOST_ADDR_CMD = 4'h0;
    localparam logic [3:0] HOST_ADDR_WDATA = 4'h4;
    localparam logic [3:0] HOST_ADDR_CTRL = 4'h8;
    localparam logic [3:0] HOST_ADDR_STATUS = 4'hc;
    localparam logic [31:0] WB_RESET_DATA = 32'h0000_0000;
    typedef enum logic [1:0] {CDD_LINK_IDLE, CDD_LINK_SEND, CDD_LINK_DONE} cdd_link_t;
endpackage

// *** shared/cdd_if.sv ***
// Link between host controller and motor device: register writes, step, halt, enable.
interface cdd_if;
    logic wr_valid;
    logic [6:0] wr_addr;
    logic [31:0] wr_data;
    logic step;
    logic step_disable_input;
    logic power_stage_enable_low;
    modport host_mp (
        output wr_valid,
        output wr_addr,
        output wr_data,
        output step,
        output step_disable_input,
        output power_stage_enable_low
    );
    modport device_mp (
        input wr_valid,
        input wr_addr,
        input wr_data,
        input step,
        input step_disable_input,
        input power_stage_enable_low
    );
endinterface

// *** hdl/cdd_coil_scale.sv ***
// Converts one signed coil value into a direction and a scaled magnitude.
module cdd_coil_scale (
    input wire logic [8:0] coil_i,
    input wire logic [4:0] scale_i,
    output logic dir_o,
    output logic [7:0] mag_o,
    output logic [7:0] abs_o
);
    import cdd_pkg::*;
    logic [8:0] abs_w;
    logic [13:0] prod_w;
    always_comb begin
        // Two's complement magnitude; -256 is clipped to the +255 end of the range.
        abs_w = coil_i[8] ? 9'(-coil_i) : coil_i;
        if (abs_w > 9'h0ff) begin
            abs_w = 9'h0ff;
        end
        dir_o = coil_i[8];
        abs_o = abs_w[7:0];
        prod_w = 14'(abs_w[7:0] * ({1'b0, scale_i} + 6'h01));
        mag_o = prod_w[12:5];
    end
endmodule

// *** hdl/cdd_device.sv ***
// Motor device end: register file, emergency stop and direct coil drive.
// What this block does
// - Enable input inactive turns stage and both duties off
// - Halt flag plus input high forces standstill
// - Enable shutdown acts after three clocks
// - Direct mode uses register, ignores step/dir
// - Coil A bits 8..0, B bits 24..16
// - Direct mode scales limit by hold current
// - Coil fields signed, -255 to +255 linear
// - Autoscale off with PWM mode bit set means open-loop voltage duty
// - Off time zero keeps stage disabled
// - Hold zero with option_a code freewheels
// - Autoscale limit is hold times amplitude
// - Larger coil regulates, scales the other
// - Hysteresis chopper regulates each bridge separately
// - Step pulse triggers run current for both
// - Host pulses step when switching solenoid on
// - Host keeps amplitudes within +-248 band (cdd_host passes coil values on unchecked)
// - Host velocity setup: full amplitude, max hold
// - Host init writes in documented order
module cdd_device (
    input wire logic clk_i,
    input wire logic rst_i,
    cdd_if.device_mp link,
    input wire logic [1:0] sense_over_i,
    output logic stage_on_o,
    output logic option_a_o,
    output logic coil_a_dir_o,
    output logic [7:0] coil_a_duty_o,
    output logic coil_b_dir_o,
    output logic [7:0] coil_b_duty_o,
    output logic [4:0] current_scale_o,
    output logic halted_o
);
    import cdd_pkg::*;
    logic [31:0] global_cfg_r;
    logic [31:0] run_hold_r;
    logic [31:0] timeout_r;
    logic [31:0] coil_direct_r;
    logic [31:0] chop_cfg_r;
    logic [31:0] vchop_cfg_r;
    logic [2:0] en_low_pipe_r;
    logic [4:0] scale_r;
    logic [7:0] idle_cnt_r;
    logic [7:0] tick_r;
    logic [3:0] ramp_cnt_r;
    logic standstill_r;
    logic step_prev_r;
    logic [1:0] chop_off_r;
    logic a_dir_w;
    logic b_dir_w;
    logic [7:0] a_mag_w;
    logic [7:0] b_mag_w;
    logic [7:0] a_abs_w;
    logic [7:0] b_abs_w;
    logic [4:0] hold_w;
    logic [4:0] run_w;
    logic halt_w;
    logic direct_w;
    logic autoscale_w;
    logic pwm_mode_w;
    logic step_edge_w;
    logic off_w;
    logic fw_w;
    logic [7:0] a_nxt;
    logic [7:0] b_nxt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            global_cfg_r <= WB_RESET_DATA;
            run_hold_r <= WB_RESET_DATA;
            timeout_r <= WB_RESET_DATA;
            coil_direct_r <= WB_RESET_DATA;
            chop_cfg_r <= WB_RESET_DATA;
            vchop_cfg_r <= WB_RESET_DATA;
        end else if (link.wr_valid) begin
            unique case (link.wr_addr)
                ADDR_GLOBAL_CONFIGURATION: global_cfg_r <= link.wr_data;
                ADDR_RUN_HOLD_CURRENT: run_hold_r <= link.wr_data;
                ADDR_STANDSTILL_TIMEOUT: timeout_r <= link.wr_data;
                ADDR_COIL_DIRECT_VALUE: begin
                    // Only the two 9-bit coil fields are stored.
                    coil_direct_r <= link.wr_data & 32'h01ff_01ff;
                end
                ADDR_CHOPPER_CONFIGURATION: chop_cfg_r <= link.wr_data;
                ADDR_VOLTAGE_CHOPPER_CONFIGURATION: vchop_cfg_r <= link.wr_data;
                default: ;
            endcase
        end
    end

    assign hold_w = run_hold_r[HOLD_LSB +: 5];
    assign run_w = run_hold_r[RUN_LSB +: 5];
    assign direct_w = global_cfg_r[GC_DIRECT_MODE_BIT];
    assign pwm_mode_w = global_cfg_r[GC_PWM_MODE_BIT];
    assign autoscale_w = vchop_cfg_r[AUTOSCALE_BIT];
    // The halt input counts only when its select flag is set.
    assign halt_w = global_cfg_r[GC_STOP_ENABLE_BIT] & link.step_disable_input;
    assign step_edge_w = link.step & ~step_prev_r & ~halt_w;

    // The enable input passes a three-stage pipe, so shutdown needs a running clock.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_low_pipe_r <= 3'h7;
            step_prev_r <= 1'b0;
        end else begin
            en_low_pipe_r <= {en_low_pipe_r[1:0], link.power_stage_enable_low};
            step_prev_r <= link.step;
        end
    end

    // Run/hold scaling: a step pulse raises to run current, standstill ramps to hold.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scale_r <= 5'h00;
            idle_cnt_r <= 8'h00;
            tick_r <= 8'h00;
            ramp_cnt_r <= 4'h0;
            standstill_r <= 1'b1;
        end else if (step_edge_w) begin
            scale_r <= run_w;
            idle_cnt_r <= 8'h00;
            tick_r <= 8'h00;
            standstill_r <= 1'b0;
        end else if (halt_w) begin
            standstill_r <= 1'b1;
            tick_r <= 8'(tick_r + 8'h01);
            if (scale_r > hold_w && tick_r == 8'(HOLD_RAMP_TICK - 1)) begin
                scale_r <= 5'(scale_r - 5'h01);
                tick_r <= 8'h00;
            end else if (scale_r < hold_w) begin
                scale_r <= hold_w;
            end
        end else begin
            tick_r <= 8'(tick_r + 8'h01);
            if (!standstill_r && tick_r == 8'(TIMEOUT_TICK - 1)) begin
                idle_cnt_r <= 8'(idle_cnt_r + 8'h01);
                if (idle_cnt_r >= timeout_r[7:0]) begin
                    standstill_r <= 1'b1;
                end
            end else if (standstill_r) begin
                // Ramp down one step per hold_ramp_delay_field x tick.
                if (scale_r > hold_w && tick_r[7:4] >= run_hold_r[HOLD_DELAY_LSB +: 4]) begin
                    scale_r <= 5'(scale_r - 5'h01);
                    tick_r <= 8'h00;
                end else if (scale_r < hold_w) begin
                    scale_r <= hold_w;
                end
            end
        end
    end

    cdd_coil_scale u_coil_a (
        .coil_i(coil_direct_r[COIL_A_LSB +: COIL_W]),
        .scale_i(scale_r),
        .dir_o(a_dir_w),
        .mag_o(a_mag_w),
        .abs_o(a_abs_w)
    );
    cdd_coil_scale u_coil_b (
        .coil_i(coil_direct_r[COIL_B_LSB +: COIL_W]),
        .scale_i(scale_r),
        .dir_o(b_dir_w),
        .mag_o(b_mag_w),
        .abs_o(b_abs_w)
    );

    // Hysteresis chopper: per-bridge over-current flag, registered from sense every clock.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chop_off_r <= 2'b00;
        end else begin
            chop_off_r <= sense_over_i;
        end
    end

    always_comb begin
        a_nxt = a_mag_w;
        b_nxt = b_mag_w;
        if (pwm_mode_w && !autoscale_w) begin
            // Open loop: the scaled duty goes out as a voltage command, sense is ignored.
            a_nxt = a_mag_w;
            b_nxt = b_mag_w;
        end else if (pwm_mode_w) begin
            // Limit follows hold scale times amplitude; the larger coil governs.
            if (sense_over_i[a_abs_w >= b_abs_w ? 0 : 1]) begin
                a_nxt = {1'b0, a_mag_w[7:1]};
                b_nxt = {1'b0, b_mag_w[7:1]};
            end
        end else begin
            if (chop_off_r[0]) begin
                a_nxt = 8'h00;
            end
            if (chop_off_r[1]) begin
                b_nxt = 8'h00;
            end
        end
    end

    assign fw_w = hold_w == 5'h00 && vchop_cfg_r[OPTION_A_LSB +: 2] == OPTION_A_OPTION_A;
    assign off_w = en_low_pipe_r[SHUTDOWN_CYCLES - 1] || chop_cfg_r[OFF_TIME_LSB +: 4] == 4'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_on_o <= 1'b0;
            option_a_o <= 1'b1;
            coil_a_dir_o <= 1'b0;
            coil_a_duty_o <= 8'h00;
            coil_b_dir_o <= 1'b0;
            coil_b_duty_o <= 8'h00;
            current_scale_o <= 5'h00;
            halted_o <= 1'b0;
        end else begin
            stage_on_o <= !off_w && direct_w;
            option_a_o <= off_w || (fw_w && standstill_r);
            coil_a_dir_o <= a_dir_w;
            coil_b_dir_o <= b_dir_w;
            coil_a_duty_o <= (off_w || !direct_w) ? 8'h00 : a_nxt;
            coil_b_duty_o <= (off_w || !direct_w) ? 8'h00 : b_nxt;
            current_scale_o <= scale_r;
            halted_o <= halt_w;
        end
    end
endmodule

// *** hdl/cdd_host.sv ***
// Host controller end: Wishbone slave that issues link writes, steps and stop levels.
module cdd_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    cdd_if.host_mp link
);
    import cdd_pkg::*;
    logic [31:0] wdata_r;
    logic [1:0] ctrl_r;
    logic busy_r;
    logic [6:0] cmd_addr_r;
    logic do_step_r;
    cdd_link_t state_r;
    logic wr_w;

    assign wr_w = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= WB_RESET_DATA;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            unique case (wb_adr_i)
                HOST_ADDR_WDATA: wb_dat_o <= wdata_r;
                HOST_ADDR_CTRL: wb_dat_o <= {30'h0, ctrl_r};
                HOST_ADDR_STATUS: wb_dat_o <= {31'h0, busy_r};
                default: wb_dat_o <= WB_RESET_DATA;
            endcase
        end
    end

    // Writes through the command register go out in the order software issues them.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdata_r <= WB_RESET_DATA;
            ctrl_r <= 2'b01;
            cmd_addr_r <= 7'h00;
            do_step_r <= 1'b0;
        end else begin
            do_step_r <= 1'b0;
            if (wr_w && wb_adr_i == HOST_ADDR_WDATA) begin
                wdata_r <= wb_dat_i;
            end
            if (wr_w && wb_adr_i == HOST_ADDR_CTRL && wb_sel_i[0]) begin
                ctrl_r <= wb_dat_i[1:0];
            end
            if (wr_w && wb_adr_i == HOST_ADDR_CMD && wb_sel_i[0] && !busy_r) begin
                cmd_addr_r <= wb_dat_i[6:0];
                // Bit 8 requests a step pulse, used when a solenoid switches on.
                do_step_r <= wb_dat_i[8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= CDD_LINK_IDLE;
            busy_r <= 1'b0;
            link.wr_valid <= 1'b0;
            link.wr_addr <= 7'h00;
            link.wr_data <= WB_RESET_DATA;
            link.step <= 1'b0;
        end else begin
            link.step <= do_step_r;
            unique case (state_r)
                CDD_LINK_IDLE: begin
                    if (wr_w && wb_adr_i == HOST_ADDR_CMD && wb_sel_i[0] && !wb_dat_i[8]) begin
                        busy_r <= 1'b1;
                        state_r <= CDD_LINK_SEND;
                    end
                end
                CDD_LINK_SEND: begin
                    link.wr_valid <= 1'b1;
                    link.wr_addr <= cmd_addr_r;
                    link.wr_data <= wdata_r;
                    state_r <= CDD_LINK_DONE;
                end
                CDD_LINK_DONE: begin
                    link.wr_valid <= 1'b0;
                    busy_r <= 1'b0;
                    state_r <= CDD_LINK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link.power_stage_enable_low <= 1'b1;
            link.step_disable_input <= 1'b0;
        end else begin
            link.power_stage_enable_low <= ctrl_r[0];
            link.step_disable_input <= ctrl_r[1];
        end
    end
endmodule

// *** testbench/cdd_chk.sv ***
// Concurrent checks on the host-to-device link and on the device's stop outputs.
module cdd_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_valid,
    input wire logic step,
    input wire logic step_disable_input,
    input wire logic power_stage_enable_low,
    input wire logic stage_on_o,
    input wire logic option_a_o,
    input wire logic halted_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_shutdown;
        $rose(power_stage_enable_low) && stage_on_o |-> ##[3:5] !stage_on_o;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("stage still on after disable");
    property p_disabled;
        power_stage_enable_low [*5] |-> !stage_on_o && option_a_o;
    endproperty
    a_disabled: assert property (p_disabled) else $error("stage drives while disabled");
    property p_stage_rise;
        $rose(stage_on_o) |-> !$past(power_stage_enable_low) && !$past(power_stage_enable_low, 3);
    endproperty
    a_stage_rise: assert property (p_stage_rise) else $error("stage on without enable");
    property p_halt;
        halted_o |-> $past(step_disable_input) || $past(step_disable_input, 2);
    endproperty
    a_halt: assert property (p_halt) else $error("halt without stop input");
    property p_wr_gap;
        wr_valid |=> !wr_valid [*2];
    endproperty
    a_wr_gap: assert property (p_wr_gap) else $error("link writes too close");
    property p_step_pulse;
        step |=> !step;
    endproperty
    a_step_pulse: assert property (p_step_pulse) else $error("step pulse too long");
    property p_step_alone;
        step |-> !wr_valid;
    endproperty
    a_step_alone: assert property (p_step_alone) else $error("step with link write");
    property p_reset_state;
        $fell(rst_i) |-> power_stage_enable_low && !stage_on_o && option_a_o && !halted_o;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    c_shutdown: cover property ($rose(power_stage_enable_low) && stage_on_o);
    c_halt: cover property ($rose(halted_o));
    c_step: cover property (step);
    c_write: cover property (wr_valid);
endmodule

// *** testbench/cdd_tb_top.sv ***
// Testbench: host and device joined by the link, driven through Wishbone.
module cdd_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cdd_pkg::*;
    typedef struct packed {
        logic [4:0] hold;
        logic [8:0] a;
        logic [8:0] b;
        logic [7:0] ea;
        logic [7:0] eb;
    } cdd_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [1:0] sense_over_i = 2'h0;
    logic stage_on_o, option_a_o, coil_a_dir_o, coil_b_dir_o, halted_o;
    logic [7:0] coil_a_duty_o, coil_b_duty_o;
    logic [4:0] current_scale_o;
    int n_fail = 0;
    int comparisons = 0;
    // Coil fields carry ones in the unused bits so a field slip shows up.
    cdd_row_t rows [5] = '{'{5'h1f, 9'h0ff, 9'h101, 8'hff, 8'hff},
        '{5'h1f, 9'h001, 9'h1ff, 8'h01, 8'h01}, '{5'h0f, 9'h0c8, 9'h19c, 8'h64, 8'h32},
        '{5'h1f, 9'h000, 9'h100, 8'h00, 8'hff}, '{5'h07, 9'h0ff, 9'h040, 8'h3f, 8'h10}};
    cdd_if link_if();
    cdd_host cdd_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link(link_if));
    cdd_device cdd_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link_if),
        .sense_over_i(sense_over_i), .stage_on_o(stage_on_o), .option_a_o(option_a_o),
        .coil_a_dir_o(coil_a_dir_o), .coil_a_duty_o(coil_a_duty_o),
        .coil_b_dir_o(coil_b_dir_o), .coil_b_duty_o(coil_b_duty_o),
        .current_scale_o(current_scale_o), .halted_o(halted_o));
    cdd_chk cdd_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .wr_valid(link_if.wr_valid),
        .step(link_if.step), .step_disable_input(link_if.step_disable_input),
        .power_stage_enable_low(link_if.power_stage_enable_low), .stage_on_o(stage_on_o),
        .option_a_o(option_a_o), .halted_o(halted_o));
    always #20 clk_i = ~clk_i;
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One classic cycle; read data is taken at the same edge that sees ack.
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        chk("bus ack", 32'h1, 32'(wb_ack_o));
        if (wb_ack_o !== 1'b1) begin
            conclude();
        end
    endtask
    // A command issued while busy is dropped, so wait until the link is idle.
    task automatic dev_wr(input logic [6:0] a, input logic [31:0] d);
        logic [31:0] q;
        int i;
        wb(HOST_ADDR_WDATA, 1'b1, d, q);
        wb(HOST_ADDR_CMD, 1'b1, {25'h0, a}, q);
        i = 0;
        do begin
            wb(HOST_ADDR_STATUS, 1'b0, 32'h0, q);
            i++;
        end while (q[0] !== 1'b0 && i < 20);
        if (q[0] !== 1'b0) begin
            chk("link idle", 32'h0, q);
            conclude();
        end
    endtask
    task automatic wait_scale(input logic [4:0] s);
        int i;
        i = 0;
        while (current_scale_o !== s && i < 4000) begin
            @(posedge clk_i);
            i++;
        end
        chk("current scale", 32'(s), 32'(current_scale_o));
        if (current_scale_o !== s) begin
            conclude();
        end
    endtask
    initial begin
        logic [31:0] q;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("stage after reset", 32'h0, 32'(stage_on_o));
        chk("coast after reset", 32'h1, 32'(option_a_o));
        wb(HOST_ADDR_CTRL, 1'b0, 32'h0, q);
        chk("ctrl reset", 32'h1, q);
        wb(4'h2, 1'b0, 32'h0, q);
        chk("unmapped read", 32'h0, q);
        // Start-up writes go out in the recommended order; the threshold is not stored here.
        dev_wr(ADDR_CHOPPER_CONFIGURATION, 32'h3);
        dev_wr(ADDR_RUN_HOLD_CURRENT, 32'h0000_1f1f);
        dev_wr(ADDR_STANDSTILL_TIMEOUT, 32'h0);
        dev_wr(ADDR_GLOBAL_CONFIGURATION, 32'h0001_0004);
        dev_wr(ADDR_VOLTAGE_CHOPPER_THRESHOLD, 32'h0);
        dev_wr(ADDR_VOLTAGE_CHOPPER_CONFIGURATION, 32'hff);
        wb(HOST_ADDR_CTRL, 1'b1, 32'h0, q);
        foreach (rows[k]) begin
            dev_wr(ADDR_RUN_HOLD_CURRENT, 32'h0000_1f00 | 32'(rows[k].hold));
            dev_wr(ADDR_COIL_DIRECT_VALUE, {7'h7f, rows[k].b, 7'h7f, rows[k].a});
            wait_scale(rows[k].hold);
            settle(4);
            chk("stage on", 32'h1, 32'(stage_on_o));
            chk("dir a", 32'(rows[k].a[8]), 32'(coil_a_dir_o));
            chk("dir b", 32'(rows[k].b[8]), 32'(coil_b_dir_o));
            chk("duty a", 32'(rows[k].ea), 32'(coil_a_duty_o));
            chk("duty b", 32'(rows[k].eb), 32'(coil_b_duty_o));
        end
        sense_over_i <= 2'h3;
        settle(8);
        chk("open loop duty", 32'h3f, 32'(coil_a_duty_o));
        sense_over_i <= 2'h0;
        dev_wr(ADDR_STANDSTILL_TIMEOUT, 32'h1);
        dev_wr(ADDR_RUN_HOLD_CURRENT, 32'h0000_1405);
        wait_scale(5'h05);
        wb(HOST_ADDR_CMD, 1'b1, 32'h100, q);
        wait_scale(5'h14);
        // Run current lifts both coils in the same cycle.
        chk("duty a at run", 32'ha7, 32'(coil_a_duty_o));
        chk("duty b at run", 32'h2a, 32'(coil_b_duty_o));
        wait_scale(5'h05);
        settle(4);
        chk("duty a after step", 32'h2f, 32'(coil_a_duty_o));
        chk("duty b after step", 32'h0c, 32'(coil_b_duty_o));
        dev_wr(ADDR_RUN_HOLD_CURRENT, 32'h0000_1f00);
        dev_wr(ADDR_VOLTAGE_CHOPPER_CONFIGURATION, 32'h0010_00ff);
        wait_scale(5'h00);
        settle(4);
        chk("option_a", 32'h1, 32'(option_a_o));
        dev_wr(ADDR_VOLTAGE_CHOPPER_CONFIGURATION, 32'hff);
        dev_wr(ADDR_RUN_HOLD_CURRENT, 32'h0000_1f1f);
        wait_scale(5'h1f);
        settle(4);
        chk("no option_a", 32'h0, 32'(option_a_o));
        // Coil A is the larger one, so only its sense input may cut the duties.
        dev_wr(ADDR_VOLTAGE_CHOPPER_CONFIGURATION, 32'h0004_00ff);
        sense_over_i <= 2'h2;
        settle(4);
        chk("smaller coil sense", 32'h40, 32'(coil_b_duty_o));
        sense_over_i <= 2'h1;
        settle(4);
        chk("limit a", 32'h7f, 32'(coil_a_duty_o));
        chk("limit b follows", 32'h20, 32'(coil_b_duty_o));
        dev_wr(ADDR_GLOBAL_CONFIGURATION, 32'h0001_0000);
        dev_wr(ADDR_COIL_DIRECT_VALUE, 32'h0108_00f8);
        settle(4);
        chk("bridge a cut", 32'h0, 32'(coil_a_duty_o));
        chk("bridge b runs", 32'hf8, 32'(coil_b_duty_o));
        sense_over_i <= 2'h0;
        settle(4);
        chk("bridge a back", 32'hf8, 32'(coil_a_duty_o));
        dev_wr(ADDR_VOLTAGE_CHOPPER_CONFIGURATION, 32'hff);
        wb(HOST_ADDR_CTRL, 1'b1, 32'h2, q);
        settle(4);
        chk("halt ignored", 32'h0, 32'(halted_o));
        dev_wr(ADDR_GLOBAL_CONFIGURATION, 32'h0001_8004);
        settle(4);
        chk("halted", 32'h1, 32'(halted_o));
        chk("halt scale", 32'h1f, 32'(current_scale_o));
        wb(HOST_ADDR_CTRL, 1'b1, 32'h0, q);
        settle(4);
        chk("halt released", 32'h0, 32'(halted_o));
        dev_wr(ADDR_CHOPPER_CONFIGURATION, 32'h0);
        settle(4);
        chk("off time zero", 32'h0, 32'(stage_on_o));
        dev_wr(ADDR_CHOPPER_CONFIGURATION, 32'h3);
        settle(4);
        chk("off time set", 32'h1, 32'(stage_on_o));
        wb(HOST_ADDR_CTRL, 1'b1, 32'h1, q);
        settle(2);
        chk("stage before delay", 32'h1, 32'(stage_on_o));
        settle(4);
        chk("stage disabled", 32'h0, 32'(stage_on_o));
        chk("coast disabled", 32'h1, 32'(option_a_o));
        dev_wr(ADDR_GLOBAL_CONFIGURATION, 32'h4);
        settle(4);
        chk("duty out of direct", 32'h0, 32'(coil_a_duty_o));
        conclude();
    end
endmodule
